/* File: hw/sfs_core.sv */
// Purpose: command handling for secure read, reset and parameter read
// Assumes: serial clock and select sampled by clk, well slower than clk
// Notes: data out changes after the falling serial edge is seen
//
// Notes on behaviour
// - 48H takes address, then one dummy byte
// - secure data MSB first on falling edge
// - start anywhere, address increments per byte
// - offset 1FFH wraps to 000H until deselect
// - address selects register one to three
// - accepted reset returns to power-on state
// - reset clears all volatile settings
// - 99H acts only after separate 66H frame
// - both opcodes accepted in either clock mode
// - commands ignored during reset recovery
// - 5AH reads parameter space
// - bytes 0-3 give signature
// - revisions and header count fixed
// - first header fields fixed
// - second header with maker byte
// - unused bytes read FFH; only address bits 7..0 are decoded, so the table repeats every 256 bytes
// - suspend sets flag, busy clears later
`timescale 1ns/1ps
`default_nettype none
module sfs_core
#(
   parameter int RECOVERY_CYC = sfs_pkg::RST_RECOVERY_CYC,
   parameter logic [7:0] MAKER_ID = sfs_pkg::MAKER_ID_DEFAULT,
   parameter int FIFO_DEPTH = 16
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n, // serial chip select pin
   input wire logic sclk, // serial clock pin
   input wire logic si, // serial data in pin
   output logic so, // serial data out
   output logic so_oe_n, // low while driving so
   output logic [7:0] sec_rd_idx, // secure array byte index low
   output logic [1:0] sec_rd_sel, // register number 0..2
   input wire logic [7:0] sec_rd_data, // byte from secure array
   input wire logic suspend_req, // program/erase suspend accepted
   input wire logic resume_req, // resume accepted
   input wire logic busy_in, // array operation running
   output logic [8:0] sec_rd_ofs_hi, // full 9-bit offset
   output logic write_enable_latch,
   output logic suspend_flag,
   output logic write_in_progress_flag,
   output logic [7:0] read_parameter_bits,
   output logic [7:0] continuous_read_mode_byte,
   output logic [2:0] wrap_setting_bits,
   output logic deep_power_down,
   output logic reset_pulse, // one cycle when reset accepted
   output logic recovering, // high during reset recovery
   input wire logic set_wel, // volatile settings from other commands
   input wire logic [7:0] set_params,
   input wire logic set_params_en
);
   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic [1:0] cs_s_q, sclk_s_q, si_s_q; // [0] read only by [1]
   logic sclk_prev_q; // last synchronised serial clock
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cs_s_q <= 2'h3;
         sclk_s_q <= 2'h0;
         si_s_q <= 2'h0;
         sclk_prev_q <= 1'b0;
      end
      else
      begin
         cs_s_q <= {cs_s_q[0], cs_n};
         sclk_s_q <= {sclk_s_q[0], sclk};
         si_s_q <= {si_s_q[0], si};
         sclk_prev_q <= sclk_s_q[1];
      end
   end
   logic cs_act, rise, fall;
   assign cs_act = !cs_s_q[1];
   // edge detection works in mode 0 and mode 3 alike
   assign rise = cs_act && sclk_s_q[1] && !sclk_prev_q;
   assign fall = cs_act && !sclk_s_q[1] && sclk_prev_q;
   // -----------------------------------------------------------------
   // command state machine
   // -----------------------------------------------------------------
   typedef enum {ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_SKIP}
      sfs_state_t;
   sfs_state_t st_q, st_d;
   logic [7:0] sh_q, sh_d; // input shift
   logic [5:0] cnt_q, cnt_d; // bit counter
   logic [7:0] opc_q, opc_d; // latched opcode
   logic [23:0] addr_q, addr_d; // current address
   logic rst_armed_q, rst_armed_d; // 66H seen in a previous frame
   logic [31:0] rec_q, rec_d; // recovery countdown
   logic [7:0] out_q, out_d; // output byte shifter
   logic [2:0] obit_q, obit_d; // output bit position
   logic so_q, so_d;
   logic cs_prev_q;
   logic frame_end, do_reset;
   logic [7:0] par_byte; // parameter space lookup
   // fifo between byte fetch and serial shifter
   logic f_in_valid, f_in_ready, f_out_valid, f_pop;
   logic [7:0] f_in_data, f_out_data;
   logic pending_q, pending_d; // fetch issued for current address
   assign frame_end = !cs_act && cs_prev_q; // first cycle after deselect
   // fixed parameter table on address bits 7..0, any other low byte reads FFH
   always_comb
   begin
      case (addr_q[7:0])
         8'h00: par_byte = 8'h53;
         8'h01: par_byte = 8'h46;
         8'h02: par_byte = 8'h44;
         8'h03: par_byte = 8'h50;
         8'h04: par_byte = 8'h00;
         8'h05: par_byte = 8'h01;
         8'h06: par_byte = 8'h01;
         8'h08: par_byte = 8'h00;
         8'h09: par_byte = 8'h00;
         8'h0A: par_byte = 8'h01;
         8'h0B: par_byte = 8'h09;
         8'h0C: par_byte = 8'h30;
         8'h10: par_byte = MAKER_ID;
         8'h11: par_byte = 8'h00;
         8'h12: par_byte = 8'h01;
         8'h13: par_byte = 8'h03;
         8'h14: par_byte = 8'h60;
         8'h0D, 8'h0E, 8'h15, 8'h16: par_byte = 8'h00;
         default: par_byte = sfs_pkg::PAR_FILL;
      endcase
   end
   // secure array address out: register from bits 15..12
   logic sec_valid;
   assign sec_valid = addr_q[23:16] == 8'h00 && addr_q[11:9] == 3'h0 &&
      addr_q[15:12] >= sfs_pkg::SEL_REG1 &&
      addr_q[15:12] <= sfs_pkg::SEL_REG3;
   assign sec_rd_sel = 2'(addr_q[13:12] - 2'h1);
   assign sec_rd_idx = addr_q[7:0];
   assign sec_rd_ofs_hi = addr_q[8:0];
   // fetch one byte per address into the fifo
   assign f_in_valid = st_q == ST_DATA && !pending_q;
   assign f_in_data = opc_q == sfs_pkg::OP_PARAM_READ ? par_byte :
      (sec_valid ? sec_rd_data : sfs_pkg::PAR_FILL);
   // next state of the command engine
   always_comb
   begin
      st_d = st_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      opc_d = opc_q;
      addr_d = addr_q;
      rst_armed_d = rst_armed_q;
      rec_d = rec_q;
      pending_d = pending_q;
      do_reset = 1'b0;
      if (rec_q != 32'h0)
         rec_d = rec_q - 32'h1;
      if (cs_act && !cs_prev_q)
      begin
         // new frame; ignored while recovering
         st_d = rec_q != 32'h0 ? ST_SKIP : ST_OPC;
         cnt_d = 6'h0;
      end
      else if (!cs_act)
      begin
         if (frame_end && st_q == ST_OPC && cnt_q == 6'h8)
         begin
            // frame closed right after eight opcode bits
            if (opc_q == sfs_pkg::OP_RST_EN)
               rst_armed_d = 1'b1;
            else if (opc_q == sfs_pkg::OP_RST && rst_armed_q)
               do_reset = 1'b1;
            else
               rst_armed_d = 1'b0;
         end
         else if (frame_end && st_q != ST_SKIP)
            rst_armed_d = 1'b0; // another command breaks the pair
         st_d = ST_IDLE;
      end
      else if (rise)
      begin
         sh_d = {sh_q[6:0], si_s_q[1]}; // sample on rising edge
         cnt_d = 6'(cnt_q + 6'h1);
         case (st_q)
            ST_OPC:
            begin
               if (cnt_q == 6'h7)
               begin
                  opc_d = {sh_q[6:0], si_s_q[1]};
                  if (opc_d == sfs_pkg::OP_SEC_READ ||
                      opc_d == sfs_pkg::OP_PARAM_READ)
                  begin
                     st_d = ST_ADDR;
                     cnt_d = 6'h0;
                  end
               end
               else if (cnt_q == 6'h8)
                  st_d = ST_SKIP; // extra bits, not a lone opcode
            end
            ST_ADDR:
            begin
               addr_d = {addr_q[22:0], si_s_q[1]};
               if (cnt_q == 6'(sfs_pkg::ADDR_BITS - 1))
               begin
                  st_d = ST_DUMMY;
                  cnt_d = 6'h0;
               end
            end
            ST_DUMMY:
            begin
               if (cnt_q == 6'(sfs_pkg::DUMMY_BITS - 1))
               begin
                  st_d = ST_DATA;
                  pending_d = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (st_q == ST_DATA && f_in_valid && f_in_ready)
      begin
         pending_d = 1'b1;
         // advance address; for 48H the offset wraps inside the register, 5AH carries through all 24 bits
         if (opc_q == sfs_pkg::OP_SEC_READ)
            addr_d = {addr_q[23:9], 9'(addr_q[8:0] + 9'h1)};
         else
            addr_d = 24'(addr_q + 24'h1);
         pending_d = 1'b0;
      end
      if (do_reset)
      begin
         rst_armed_d = 1'b0;
         rec_d = 32'(RECOVERY_CYC);
      end
   end
   // -----------------------------------------------------------------
   // output shifter
   // -----------------------------------------------------------------
   assign f_pop = st_q == ST_DATA && fall && obit_q == 3'h0;
   always_comb
   begin
      out_d = out_q;
      obit_d = obit_q;
      so_d = so_q;
      if (st_q != ST_DATA)
         obit_d = 3'h0;
      else if (fall)
      begin
         // msb first, changed on falling edge
         if (obit_q == 3'h0)
         begin
            so_d = f_out_data[7];
            out_d = {f_out_data[6:0], 1'b0};
         end
         else
         begin
            so_d = out_q[7];
            out_d = {out_q[6:0], 1'b0};
         end
         obit_d = 3'(obit_q + 3'h1);
      end
   end
   sfs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk(clk),
      .rst(rst),
      .flush(st_q != ST_DATA),
      .in_data(f_in_data),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .out_data(f_out_data),
      .out_valid(f_out_valid),
      .out_ready(f_pop)
   );
   // -----------------------------------------------------------------
   // volatile settings, cleared by accepted reset
   // -----------------------------------------------------------------
   logic wel_q, wel_d, sus_q, sus_d, wip_q, wip_d, dpd_q, dpd_d;
   logic [7:0] par_q, par_d, mode_q, mode_d;
   logic [2:0] wrap_q, wrap_d;
   always_comb
   begin
      wel_d = wel_q | set_wel;
      par_d = set_params_en ? set_params : par_q;
      mode_d = mode_q;
      wrap_d = wrap_q;
      dpd_d = dpd_q;
      sus_d = sus_q;
      wip_d = busy_in;
      if (suspend_req && !sus_q && busy_in)
         sus_d = 1'b1; // flag at once, busy drops with the array
      else if (resume_req)
         sus_d = 1'b0;
      if (do_reset)
      begin
         // everything volatile back to power-on values
         wel_d = 1'b0;
         sus_d = 1'b0;
         wip_d = 1'b0;
         par_d = 8'h00;
         mode_d = 8'h00;
         wrap_d = 3'h0;
         dpd_d = 1'b0;
      end
   end
   assign write_enable_latch = wel_q;
   assign suspend_flag = sus_q;
   assign write_in_progress_flag = wip_q;
   assign read_parameter_bits = par_q;
   assign continuous_read_mode_byte = mode_q;
   assign wrap_setting_bits = wrap_q;
   assign deep_power_down = dpd_q;
   assign reset_pulse = do_reset;
   assign recovering = rec_q != 32'h0;
   assign so = so_q;
   assign so_oe_n = !(st_q == ST_DATA && cs_act);
   // all state registers apart from the pin synchronisers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_q <= ST_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 6'h0;
         opc_q <= 8'h00;
         addr_q <= 24'h0;
         rst_armed_q <= 1'b0;
         rec_q <= 32'h0;
         pending_q <= 1'b0;
         out_q <= 8'h00;
         obit_q <= 3'h0;
         so_q <= 1'b0;
         cs_prev_q <= 1'b0;
         wel_q <= 1'b0;
         sus_q <= 1'b0;
         wip_q <= 1'b0;
         dpd_q <= 1'b0;
         par_q <= 8'h00;
         mode_q <= 8'h00;
         wrap_q <= 3'h0;
      end
      else
      begin
         st_q <= st_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         opc_q <= opc_d;
         addr_q <= addr_d;
         rst_armed_q <= rst_armed_d;
         rec_q <= rec_d;
         pending_q <= pending_d;
         out_q <= out_d;
         obit_q <= obit_d;
         so_q <= so_d;
         cs_prev_q <= cs_act;
         wel_q <= wel_d;
         sus_q <= sus_d;
         wip_q <= wip_d;
         dpd_q <= dpd_d;
         par_q <= par_d;
         mode_q <= mode_d;
         wrap_q <= wrap_d;
      end
   end
endmodule
`default_nettype wire

/* File: hw/sfs_fifo.sv */
// Purpose: small synchronous FIFO for outgoing bytes
// Assumes: one clock, depth a power of two
// Notes: valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sfs_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH]; // storage
   logic [AW:0] wr_q, wr_d, rd_q, rd_d; // pointers with wrap bit
   logic push, pop;
   // -----------------------------------------------------------------
   // flags
   // -----------------------------------------------------------------
   assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid = wr_q != rd_q;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rd_q[AW-1:0]];
   // pointer next values
   always_comb
   begin
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      if (flush)
      begin
         wr_d = '0;
         rd_d = '0;
      end
   end
   // pointer registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end
   // storage write, no reset needed for data
   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wr_q[AW-1:0]] <= in_data;
   end
endmodule
`default_nettype wire

/* File: hw/sfs_pkg.sv */
// Purpose: shared constants for the serial flash secure-read/reset/param block
// Assumes: 24-bit addressing, single-bit serial data
// Notes: shared offsets and counts live here; the parameter table offsets and FIFO_DEPTH sit in sfs_core
package sfs_pkg;
   // -----------------------------------------------------------------
   // opcodes
   // -----------------------------------------------------------------
   localparam logic [7:0] OP_SEC_READ = 8'h48;
   localparam logic [7:0] OP_RST_EN = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;
   localparam logic [7:0] OP_PARAM_READ = 8'h5A;
   // -----------------------------------------------------------------
   // address fields
   // -----------------------------------------------------------------
   localparam int ADDR_BITS = 24;
   localparam int OFS_BITS = 9;
   localparam logic [3:0] SEL_REG1 = 4'h1;
   localparam logic [3:0] SEL_REG3 = 4'h3;
   localparam logic [8:0] OFS_LAST = 9'h1FF;
   localparam logic [8:0] OFS_FIRST = 9'h000;
   localparam int SEC_BYTES = 512;
   localparam int SEC_COUNT = 3;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int RST_RECOVERY_NS = 30000;
   // longest time rounds down, at least one cycle
   localparam int RST_RECOVERY_CYC =
      (RST_RECOVERY_NS / CLK_PERIOD_NS) < 1 ? 1 :
      (RST_RECOVERY_NS / CLK_PERIOD_NS);
   localparam int DUMMY_BITS = 8;
   // -----------------------------------------------------------------
   // parameter space bytes
   // -----------------------------------------------------------------
   localparam logic [7:0] PAR_FILL = 8'hFF;
   localparam logic [7:0] MAKER_ID_DEFAULT = 8'h5C; // arbitrary value
endpackage

/* File: tb/sfs_core_assertions.sv */
// Purpose: port-level checks on the command block
// Assumes: one clock domain, rst async active high
// Notes: attached by the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module sfs_core_checker
#(
   parameter int RECOVERY_CYC = 10
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic so,
   input wire logic so_oe_n,
   input wire logic suspend_req,
   input wire logic busy_in,
   input wire logic suspend_flag,
   input wire logic write_enable_latch,
   input wire logic [7:0] read_parameter_bits,
   input wire logic [7:0] continuous_read_mode_byte,
   input wire logic [2:0] wrap_setting_bits,
   input wire logic deep_power_down,
   input wire logic reset_pulse,
   input wire logic recovering
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // recovery length counter
   // ------------------------------------------------------------
   int unsigned rec_q; // cycles recovering has stood high
   int unsigned rec_d; // next count
   // a counter keeps the long window cheap for the tools
   always_comb
   begin
      rec_d = recovering ? rec_q + 1 : 0;
   end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rec_q <= 0;
      else
         rec_q <= rec_d;
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   a_oe_when_idle:
      assert property (cs_n [*5] |-> so_oe_n)
      else $error("so driven while deselected");
   a_so_after_fall:
      assert property ($changed(so) && !so_oe_n && !$past(so_oe_n) |->
         !$past(sclk, 2) || !$past(sclk, 3) || !$past(sclk, 4))
      else $error("so moved without a falling serial clock");
   a_pulse_single:
      assert property (reset_pulse |=> !reset_pulse)
      else $error("reset pulse longer than one cycle");
   a_pulse_recover:
      assert property (reset_pulse |-> ##[0:1] recovering)
      else $error("no recovery after accepted reset");
   a_no_pulse_recov:
      assert property (recovering && $past(recovering) |-> !reset_pulse)
      else $error("reset accepted during recovery");
   a_recover_max:
      assert property (rec_q <= RECOVERY_CYC + 1)
      else $error("recovery lasts too long");
   a_recover_min:
      assert property ($fell(recovering) |-> rec_q >= RECOVERY_CYC - 1)
      else $error("recovery ended early");
   a_reset_clears:
      assert property (reset_pulse |=> !write_enable_latch && !suspend_flag
         && read_parameter_bits == 8'h00 && !deep_power_down
         && continuous_read_mode_byte == 8'h00 && wrap_setting_bits == 3'h0)
      else $error("volatile state kept over reset");
   a_suspend_set:
      assert property (suspend_req && busy_in && !suspend_flag && !recovering
         && !reset_pulse |-> ##[1:2] suspend_flag)
      else $error("suspend flag not set");
   c_reset: cover property (reset_pulse);
   c_data: cover property ($fell(so_oe_n));
   c_suspend: cover property ($rose(suspend_flag));
endmodule
bind sfs_core sfs_core_checker #(.RECOVERY_CYC(RECOVERY_CYC)) u_chk (
   .clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .so(so),
   .so_oe_n(so_oe_n), .suspend_req(suspend_req), .busy_in(busy_in),
   .suspend_flag(suspend_flag), .write_enable_latch(write_enable_latch),
   .read_parameter_bits(read_parameter_bits),
   .continuous_read_mode_byte(continuous_read_mode_byte),
   .wrap_setting_bits(wrap_setting_bits),
   .deep_power_down(deep_power_down), .reset_pulse(reset_pulse),
   .recovering(recovering));
`default_nettype wire

/* File: tb/sfs_host_model.sv */
// Purpose: host side of the serial link
// Assumes: 800 ns serial period, paced by clk falling edges
// Notes: mode 0 idles sclk low, mode 3 idles it high
`timescale 1ns/1ps
`default_nettype none
module sfs_host_model
(
   input wire logic clk,
   output logic cs_n,
   output logic sclk,
   output logic si,
   input wire logic so
);
   logic cpol; // idle clock level of the frame in progress
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
      cpol = 1'b0;
   end
   // select the device with the clock at its idle level
   task automatic open_frame(input logic mode3);
      @(negedge clk);
      cpol = mode3;
      sclk = mode3;
      // settle the idle level before select, so no edge meets the frame
      @(negedge clk);
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   // one byte each way, msb first; so is read just before the rise
   task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         sclk = 1'b0;
         si = tx[i];
         repeat (4) @(negedge clk);
         rx[i] = so;
         sclk = 1'b1;
         repeat (4) @(negedge clk);
      end
   endtask
   // park the clock before deselect; in mode 0 this puts one falling edge inside the frame
   task automatic close_frame();
      sclk = cpol;
      repeat (2) @(negedge clk);
      cs_n = 1'b1;
      si = ~si; // an undriven line shows no stale value
      repeat (8) @(negedge clk);
   endtask
endmodule
`default_nettype wire

/* File: tb/test_serial_flash_secreg_reset_sfdp.sv */
// Purpose: self-checking bench for the command block
// Assumes: recovery shortened to REC cycles
// Notes: secure array modelled as a pattern of select and offset
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_secreg_reset_sfdp;
   localparam int REC = 200; // shortened recovery count
   localparam logic [7:0] MAKER = 8'h3A; // arbitrary value
   localparam logic [7:0] PAR_EXP [24] = '{8'h53, 8'h46, 8'h44, 8'h50,
      8'h00, 8'h01, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00,
      8'h00, 8'hFF, MAKER, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hFF};
   logic clk, rst, cs_n, sclk, si, so, so_oe_n, suspend_req, resume_req;
   logic busy_in, write_enable_latch, suspend_flag, write_in_progress_flag;
   logic deep_power_down, reset_pulse, recovering, set_wel, set_params_en;
   logic [7:0] sec_rd_idx, sec_rd_data, read_parameter_bits, set_params;
   logic [7:0] continuous_read_mode_byte;
   logic [1:0] sec_rd_sel;
   logic [8:0] sec_rd_ofs_hi;
   logic [2:0] wrap_setting_bits;
   logic [7:0] got [32]; // bytes of the last read
   int failures = 0;
   int num_checks = 0;
   int pulses = 0; // accepted resets seen
   // secure array content, offset low byte XORed with offset bit 8 and register number
   function automatic logic [7:0] arr_byte(logic [1:0] s, logic [8:0] o);
      return o[7:0] ^ {o[8], s, 5'h00};
   endfunction
   assign sec_rd_data = arr_byte(sec_rd_sel, {sec_rd_ofs_hi[8], sec_rd_idx});
   sfs_core #(.RECOVERY_CYC(REC), .MAKER_ID(MAKER), .FIFO_DEPTH(16)) dut (
      .clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
      .so_oe_n(so_oe_n), .sec_rd_idx(sec_rd_idx), .sec_rd_sel(sec_rd_sel),
      .sec_rd_data(sec_rd_data), .suspend_req(suspend_req),
      .resume_req(resume_req), .busy_in(busy_in),
      .sec_rd_ofs_hi(sec_rd_ofs_hi), .write_enable_latch(write_enable_latch),
      .suspend_flag(suspend_flag),
      .write_in_progress_flag(write_in_progress_flag),
      .read_parameter_bits(read_parameter_bits),
      .continuous_read_mode_byte(continuous_read_mode_byte),
      .wrap_setting_bits(wrap_setting_bits),
      .deep_power_down(deep_power_down), .reset_pulse(reset_pulse),
      .recovering(recovering), .set_wel(set_wel), .set_params(set_params),
      .set_params_en(set_params_en));
   sfs_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si),
      .so(so));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
      if (reset_pulse === 1'b1)
         pulses <= pulses + 1;
   // status bits packed: wip, wel, suspend, power-down, recovering, oe_n
   function automatic logic [7:0] flags();
      return {2'h0, write_in_progress_flag, write_enable_latch,
         suspend_flag, deep_power_down, recovering, so_oe_n};
   endfunction
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // opcode, address, dummy byte, then n data bytes into got
   task automatic read_bytes(logic [7:0] op, logic [23:0] a, int n);
      logic [7:0] rx;
      host.open_frame(1'b0);
      host.shift(op, rx);
      for (int i = 2; i >= 0; i--)
         host.shift(a[8*i +: 8], rx);
      host.shift(8'h00, rx);
      for (int i = 0; i < n; i++)
      begin
         host.shift(8'h00, rx);
         got[i] = rx;
      end
      host.close_frame();
   endtask
   // a frame holding one opcode only
   task automatic one_op(logic mode3, logic [7:0] op);
      logic [7:0] rx;
      host.open_frame(mode3);
      host.shift(op, rx);
      host.close_frame();
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // watchdog: the whole run needs about 5200 cycles
   initial
   begin
      repeat (40000) @(posedge clk);
      failures++;
      stop_test();
   end
   initial
   begin
      rst = 1'b1;
      {suspend_req, resume_req, busy_in, set_wel, set_params_en} = 5'h00;
      set_params = 8'h00;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      check("idle flags", flags(), 8'h01);
      // wrap from the last offset in each register, then a bad select
      for (int r = 1; r <= 3; r++)
      begin
         read_bytes(sfs_pkg::OP_SEC_READ, {8'h00, 4'(r), 3'h0, 9'h1FE}, 4);
         for (int i = 0; i < 4; i++)
            check("secure", got[i], arr_byte(2'(r - 1), 9'(9'h1FE + i)));
      end
      read_bytes(sfs_pkg::OP_SEC_READ, 24'h004000, 1);
      check("bad select", got[0], 8'hFF);
      $display("secure read test done");
      read_bytes(sfs_pkg::OP_PARAM_READ, 24'h000000, 24);
      for (int i = 0; i < 24; i++)
         check("param", got[i], PAR_EXP[i]);
      $display("parameter read test done");
      // load volatile state, then reset in mode 3
      {set_wel, set_params_en, busy_in, suspend_req} = 4'hF;
      set_params = 8'h5A;
      @(negedge clk);
      {set_wel, set_params_en, suspend_req} = 3'h0;
      repeat (3) @(negedge clk);
      check("loaded", flags(), 8'h39);
      check("params", read_parameter_bits, 8'h5A);
      resume_req = 1'b1; // resume drops the flag, suspend sets it again
      @(negedge clk);
      resume_req = 1'b0;
      @(negedge clk);
      check("resumed", {7'h00, suspend_flag}, 8'h00);
      suspend_req = 1'b1;
      @(negedge clk);
      suspend_req = 1'b0;
      @(negedge clk);
      check("suspended", {7'h00, suspend_flag}, 8'h01);
      busy_in = 1'b0; // idle before reset
      one_op(1'b1, sfs_pkg::OP_RST_EN);
      one_op(1'b1, sfs_pkg::OP_RST);
      check("pulses", 8'(pulses), 8'h01);
      check("cleared", flags(), 8'h03);
      check("params", read_parameter_bits, 8'h00);
      check("mode wrap", continuous_read_mode_byte |
         {5'h00, wrap_setting_bits}, 8'h00);
      one_op(1'b0, sfs_pkg::OP_RST_EN);
      one_op(1'b0, sfs_pkg::OP_RST);
      check("ignored", 8'(pulses), 8'h01);
      repeat (REC) @(negedge clk);
      check("recovered", flags(), 8'h01);
      $display("reset test done");
      // lone reset, broken pair, then a proper pair in mode 0
      one_op(1'b0, sfs_pkg::OP_RST);
      check("lone", 8'(pulses), 8'h01);
      one_op(1'b0, sfs_pkg::OP_RST_EN);
      one_op(1'b0, sfs_pkg::OP_PARAM_READ);
      one_op(1'b0, sfs_pkg::OP_RST);
      check("split", 8'(pulses), 8'h01);
      one_op(1'b0, sfs_pkg::OP_RST_EN);
      one_op(1'b0, sfs_pkg::OP_RST);
      check("pair", 8'(pulses), 8'h02);
      repeat (REC + 10) @(negedge clk);
      $display("order test done");
      stop_test();
   end
endmodule
`default_nettype wire
